// >>> hw/port4_alternate_function_mux.v
// Port-4 pin-function multiplexer with APB register slave
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "pin_mux_defs.vh"

module port4_alternate_function_mux (
  // APB
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Package pins, split into in, out, enable
  input  wire [4:0]  pin_in,
  output reg  [4:0]  pin_out,
  output reg  [4:0]  pin_oe,
  // Debug select pin level
  input  wire        debug_select_pin,
  // Serial interface
  output reg         serial_if0_data_in,
  input  wire        serial_if0_data_out,
  input  wire        serial_if0_clock_out,
  input  wire        serial_if0_clock_oe,
  output reg         serial_if0_clock_in,
  // Async serial channel
  output reg         async0_receive,
  input  wire        async0_transmit,
  // Timer outputs
  input  wire        timer_a0_out0,
  input  wire        timer_a1_out0,
  input  wire        timer_a1_out1,
  // External interrupt inputs and their edge enables
  output reg         ext_irq13,
  output reg         ext_irq14,
  output wire        falling_edge_enable13,
  output wire        rising_edge_enable13,
  output wire        falling_edge_enable14,
  output wire        rising_edge_enable14,
  // Debug unit inputs
  output reg         debug_data_in,
  output reg         debug_clock_in,
  output reg         debug_mode_select_in
);

  // ==========================================================================
  // Control registers
  // Field register outputs; the flops sit in the instances below
  wire [4:0] port_latch_ff;
  wire [4:0] direction_bit_ff;
  wire [4:0] mode_control_bit_ff;
  wire [4:0] function_control_bit_ff;
  wire [4:0] function_extension_bit_ff;
  wire [3:0] edge_enable_ff;

  // ==========================================================================
  // Register bus decode
  // Access-phase write qualifier
  wire wr_en = psel & penable & pwrite;
  wire addr_ok = (paddr == `OFS_PORT_LATCH) | (paddr == `OFS_DIRECTION) |
                 (paddr == `OFS_MODE_CTRL) | (paddr == `OFS_FUNC_CTRL) |
                 (paddr == `OFS_FUNC_EXT) | (paddr == `OFS_PIN_LEVEL) |
                 (paddr == `OFS_EDGE_ENABLE) | (paddr == `OFS_STATUS);

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // ==========================================================================
  // Field registers
  // Write strobes; read-only and unmapped offsets get none, so writes there drop
  wire wr_latch = wr_en & (paddr == `OFS_PORT_LATCH);
  wire wr_dir   = wr_en & (paddr == `OFS_DIRECTION);
  wire wr_mode  = wr_en & (paddr == `OFS_MODE_CTRL);
  wire wr_func  = wr_en & (paddr == `OFS_FUNC_CTRL);
  wire wr_ext   = wr_en & (paddr == `OFS_FUNC_EXT);
  wire wr_edge  = wr_en & (paddr == `OFS_EDGE_ENABLE);

  // Port latch; only reaches a pad in port mode
  pin_ctrl_reg #(
    .WIDTH     (5),
    .RST_VALUE (`RST_PORT_LATCH)
  ) u_port_latch (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_stb   (wr_latch),
    .wr_data  (pwdata[4:0]),
    .value_ff (port_latch_ff)
  );

  // Direction; resets to all inputs so no pad is driven before software
  pin_ctrl_reg #(
    .WIDTH     (5),
    .RST_VALUE (`RST_DIRECTION)
  ) u_direction (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_stb   (wr_dir),
    .wr_data  (pwdata[4:0]),
    .value_ff (direction_bit_ff)
  );

  // Mode control; one bit per pin picks port or alternate use
  pin_ctrl_reg #(
    .WIDTH     (5),
    .RST_VALUE (`RST_MODE_CTRL)
  ) u_mode_control (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_stb   (wr_mode),
    .wr_data  (pwdata[4:0]),
    .value_ff (mode_control_bit_ff)
  );

  // Function control; pins without this choice simply ignore their bit
  pin_ctrl_reg #(
    .WIDTH     (5),
    .RST_VALUE (`RST_FUNC_CTRL)
  ) u_function_control (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_stb   (wr_func),
    .wr_data  (pwdata[4:0]),
    .value_ff (function_control_bit_ff)
  );

  // Function extension; only pins 0 and 2 look at it
  pin_ctrl_reg #(
    .WIDTH     (5),
    .RST_VALUE (`RST_FUNC_EXT)
  ) u_function_extension (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_stb   (wr_ext),
    .wr_data  (pwdata[4:0]),
    .value_ff (function_extension_bit_ff)
  );

  // Edge enables for the two interrupt pins
  pin_ctrl_reg #(
    .WIDTH     (4),
    .RST_VALUE (`RST_EDGE_ENABLE)
  ) u_edge_enable (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_stb   (wr_edge),
    .wr_data  (pwdata[3:0]),
    .value_ff (edge_enable_ff)
  );

  // ==========================================================================
  // Interrupt edge enables
  // Edge enables go straight to the interrupt controller; software owns them
  assign falling_edge_enable13 = edge_enable_ff[`EDGE_FALL13];
  assign rising_edge_enable13  = edge_enable_ff[`EDGE_RISE13];
  assign falling_edge_enable14 = edge_enable_ff[`EDGE_FALL14];
  assign rising_edge_enable14  = edge_enable_ff[`EDGE_RISE14];

  // ==========================================================================
  // Register read-back
  // Limitation: pin levels read back are those seen at the setup edge
  // Read data registered in setup phase so it is valid at the access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `OFS_PORT_LATCH:  prdata <= {27'h0000000, port_latch_ff};
        `OFS_DIRECTION:   prdata <= {27'h0000000, direction_bit_ff};
        `OFS_MODE_CTRL:   prdata <= {27'h0000000, mode_control_bit_ff};
        `OFS_FUNC_CTRL:   prdata <= {27'h0000000, function_control_bit_ff};
        `OFS_FUNC_EXT:    prdata <= {27'h0000000, function_extension_bit_ff};
        `OFS_PIN_LEVEL:   prdata <= {27'h0000000, pin_in};
        `OFS_EDGE_ENABLE: prdata <= {28'h0000000, edge_enable_ff};
        `OFS_STATUS:      prdata <= {31'h00000000, debug_select_pin};
        default:          prdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // Pin routing
  wire [4:0] mc = mode_control_bit_ff;
  wire [4:0] fc = function_control_bit_ff;
  wire [4:0] fe = function_extension_bit_ff;

  // Function selects per pin; a clear mode bit closes every alternate path
  // Pin 0 with fc 0 and fe 1 selects nothing and is left as a plain input
  wire pin0_serial_sel = mc[0] & ~fc[0] & ~fe[0];
  wire pin0_rx_sel     = mc[0] &  fc[0] & ~fe[0];
  wire pin0_timer_sel  = mc[0] &  fc[0] &  fe[0];
  wire pin1_tx_sel     = mc[1] &  fc[1];
  wire pin2_clock_sel  = mc[2] & ~fe[2];
  wire pin2_timer_sel  = mc[2] &  fe[2];
  wire pin3_irq_sel    = mc[3] & ~fc[3];
  wire pin3_timer_sel  = mc[3] &  fc[3];
  wire pin4_irq_sel    = mc[4];

  // Combinational mux; pins behave like pads, so no register delay here
  always @* begin
    // Mode 0: general port, direction bit 0 drives the latch out
    pin_out = port_latch_ff;
    pin_oe  = ~direction_bit_ff;
    // Peripheral inputs rest at their idle levels until a select picks the pad
    serial_if0_data_in   = 1'b1;
    serial_if0_clock_in  = 1'b1;
    async0_receive       = 1'b1;
    ext_irq13            = 1'b0;
    ext_irq14            = 1'b0;
    debug_data_in        = 1'b0;
    debug_clock_in       = 1'b0;
    debug_mode_select_in = 1'b0;
    // Alternate functions ignore latch and direction
    // Pin 0: only the timer drives the pad, the two inputs leave it floating
    if (mc[0]) begin
      pin_out[0] = pin0_timer_sel & timer_a0_out0;
      pin_oe[0]  = pin0_timer_sel;
      if (pin0_rx_sel) begin
        async0_receive = pin_in[0];
      end
      if (pin0_serial_sel) begin
        serial_if0_data_in = pin_in[0];
      end
    end
    // Pin 1: output only, so either choice drives the pad
    if (mc[1]) begin
      pin_oe[1]  = 1'b1;
      pin_out[1] = pin1_tx_sel ? async0_transmit : serial_if0_data_out;
    end
    // Pin 2: the serial peripheral owns the clock pad direction
    if (mc[2]) begin
      if (pin2_timer_sel) begin
        pin_out[2] = timer_a1_out0;
        pin_oe[2]  = 1'b1;
      end else begin
        pin_out[2] = serial_if0_clock_out;
        pin_oe[2]  = serial_if0_clock_oe;
      end
      if (pin2_clock_sel) begin
        serial_if0_clock_in = pin_in[2];
      end
    end
    // Pin 3: interrupt use floats the pad so only the far side sets it
    if (mc[3]) begin
      pin_out[3] = pin3_timer_sel & timer_a1_out1;
      pin_oe[3]  = pin3_timer_sel;
      if (pin3_irq_sel) begin
        ext_irq13 = pin_in[3];
      end
    end
    // Pin 4: interrupt input only; the edge choice is left to software
    if (pin4_irq_sel) begin
      pin_out[4] = 1'b0;
      pin_oe[4]  = 1'b0;
      ext_irq14  = pin_in[4];
    end
    // Debug select wins over the control bits of pins 0, 2 and 3; low leaves the above alone
    if (debug_select_pin) begin
      // Pads float and their peripheral inputs go idle, so debug traffic never leaks
      pin_out[0] = 1'b0;
      pin_oe[0]  = 1'b0;
      pin_out[2] = 1'b0;
      pin_oe[2]  = 1'b0;
      pin_out[3] = 1'b0;
      pin_oe[3]  = 1'b0;
      serial_if0_data_in   = 1'b1;
      async0_receive       = 1'b1;
      serial_if0_clock_in  = 1'b1;
      ext_irq13            = 1'b0;
      debug_data_in        = pin_in[0];
      debug_clock_in       = pin_in[2];
      debug_mode_select_in = pin_in[3];
    end
  end

endmodule // port4_alternate_function_mux

// ==========================================================================
// One software-written control field; same flop shape for every field
// Limitation: no byte strobes, a write always replaces the whole field
module pin_ctrl_reg #(
  parameter             WIDTH     = 5,
  parameter [WIDTH-1:0] RST_VALUE = {WIDTH{1'b0}}
) (
  // Clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // Write strobe and data
  input  wire             wr_stb,
  input  wire [WIDTH-1:0] wr_data,
  // Stored value
  output reg  [WIDTH-1:0] value_ff
);

  // Load at the access edge, hold otherwise; reset uses only the constant
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_ff <= RST_VALUE;
    end else if (wr_stb) begin
      value_ff <= wr_data;
    end
  end

endmodule // pin_ctrl_reg

// >>> hw/pin_mux_defs.vh
// Constants, register map and field positions of the port-4 pin-function multiplexer
// ==========================================================================
`ifndef PIN_MUX_DEFS_VH
`define PIN_MUX_DEFS_VH

// ==========================================================================
// Register byte offsets
`define OFS_PORT_LATCH  12'h000
`define OFS_DIRECTION   12'h004
`define OFS_MODE_CTRL   12'h008
`define OFS_FUNC_CTRL   12'h00C
`define OFS_FUNC_EXT    12'h010
`define OFS_PIN_LEVEL   12'h014
`define OFS_EDGE_ENABLE 12'h018
`define OFS_STATUS      12'h01C

// ==========================================================================
// Widths and reset values
`define NUM_PINS        5
`define RST_PORT_LATCH  5'h00
`define RST_DIRECTION   5'h1F
`define RST_MODE_CTRL   5'h00
`define RST_FUNC_CTRL   5'h00
`define RST_FUNC_EXT    5'h00
`define RST_EDGE_ENABLE 4'h0

// Edge-enable field positions
`define EDGE_FALL13 0
`define EDGE_RISE13 1
`define EDGE_FALL14 2
`define EDGE_RISE14 3

// Status field position
`define STAT_DEBUG_SEL 0

`endif

// >>> verif/pin_mux_props.sv
// Checker for the port-4 pin multiplexer
`timescale 1ns/1ps
module pin_mux_props (
  // Clock and reset
  input logic       pclk,
  input logic       presetn,
  // Pins and debug select
  input logic       debug_select_pin,
  input logic [4:0] pin_in,
  input logic [4:0] pin_oe,
  // Routed inputs
  input logic       async0_receive,
  input logic       ext_irq13,
  input logic       ext_irq14,
  input logic       debug_data_in,
  input logic       debug_clock_in,
  input logic       debug_mode_select_in
);
  // ==========================================
  // Routing properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_dbg_data: assert property (debug_select_pin |-> debug_data_in == pin_in[0]) else $error("debug data");
  a_dbg_clock: assert property (debug_select_pin |-> debug_clock_in == pin_in[2]) else $error("debug clock");
  a_dbg_mode: assert property (debug_select_pin |-> debug_mode_select_in == pin_in[3]) else $error("debug mode");
  a_dbg_float: assert property (debug_select_pin |-> (pin_oe & 5'h0D) == 5'h00) else $error("pin driven");
  a_dbg_idle: assert property (!debug_select_pin |-> !(debug_data_in | debug_clock_in | debug_mode_select_in))
    else $error("debug idle");
  a_rx_source: assert property (!async0_receive |-> !pin_in[0] && !debug_select_pin) else $error("receive");
  a_irq13_source: assert property (ext_irq13 |-> pin_in[3] && !debug_select_pin) else $error("irq13");
  a_irq14_source: assert property (ext_irq14 |-> pin_in[4]) else $error("irq14");
  // Main scenarios reached
  cover property (debug_select_pin && debug_data_in);
  cover property (ext_irq13);
  cover property (!async0_receive);
endmodule // pin_mux_props
bind port4_alternate_function_mux pin_mux_props u_props (.*);

// >>> verif/pin_world.sv
// Model of the pins and peripherals around the multiplexer
`timescale 1ns/1ps
module pin_world (
  // Clock
  input logic        pclk,
  // Design drive of the pins
  input logic  [4:0] pin_out,
  input logic  [4:0] pin_oe,
  // Pin levels and peripheral drive
  output logic [4:0] pin_in,
  output logic [6:0] per
);
  logic [15:0] lfsr_ff = 16'hACE1;
  // Far side changes each cycle so stale values never pass
  always @(posedge pclk) lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
  assign per = lfsr_ff[11:5];
  // Driven bit wins over the outside source
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & lfsr_ff[4:0]);
endmodule // pin_world

// >>> verif/port4_alternate_function_mux_tb.sv
// Self-checking bench for the port-4 pin multiplexer
`timescale 1ns/1ps
module port4_alternate_function_mux_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, dbg = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sdi, sci, rx, i13, i14, dd, dc, dm;
  logic [4:0] pin_in, pin_out, pin_oe, eo, ee, ep, m, c, e;
  logic [6:0] per;
  logic [3:0] een;
  int errors = 0, checked = 0, v[5];
  // ==========================================
  // Clock, design and far side
  always #12.5 pclk = ~pclk;
  port4_alternate_function_mux u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pin_in, .pin_out, .pin_oe, .debug_select_pin(dbg), .serial_if0_data_in(sdi),
    .serial_if0_data_out(per[0]), .serial_if0_clock_out(per[1]), .serial_if0_clock_oe(per[2]),
    .serial_if0_clock_in(sci), .async0_receive(rx), .async0_transmit(per[3]), .timer_a0_out0(per[4]),
    .timer_a1_out0(per[5]), .timer_a1_out1(per[6]), .ext_irq13(i13), .ext_irq14(i14), .falling_edge_enable13(een[0]),
    .rising_edge_enable13(een[1]), .falling_edge_enable14(een[2]), .rising_edge_enable14(een[3]), .debug_data_in(dd),
    .debug_clock_in(dc), .debug_mode_select_in(dm));
  pin_world u_world (.pclk, .pin_out, .pin_oe, .pin_in, .per);
  // ==========================================
  // Bus cycle, comparison and verdict
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Reference routing built from integers
  task automatic model();
    m = v[2][4:0];
    c = v[3][4:0];
    e = v[4][4:0];
    ee = ~v[1][4:0] & ~m;
    eo = v[0][4:0];
    ee[0] = m[0] ? c[0] & e[0] : ee[0];
    eo[0] = m[0] ? per[4] : eo[0];
    ee[1] = m[1] | ee[1];
    eo[1] = m[1] ? (c[1] ? per[3] : per[0]) : eo[1];
    ee[2] = m[2] ? e[2] | per[2] : ee[2];
    eo[2] = m[2] ? (e[2] ? per[5] : per[1]) : eo[2];
    ee[3] = m[3] ? c[3] : ee[3];
    eo[3] = m[3] ? per[6] : eo[3];
    ee = dbg ? ee & 5'h12 : ee;
    ep[4] = !dbg && m[0] && !c[0] && !e[0] ? pin_in[0] : 1'b1;
    ep[3] = !dbg && m[0] && c[0] && !e[0] ? pin_in[0] : 1'b1;
    ep[2] = !dbg && m[2] && !e[2] ? pin_in[2] : 1'b1;
    ep[1] = !dbg && m[3] && !c[3] ? pin_in[3] : 1'b0;
    ep[0] = m[4] ? pin_in[4] : 1'b0;
  endtask
  // Hang guard, far beyond the expected run length
  initial begin
    #200us;
    errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    void'($urandom(61));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h004, 0);
    chk(rd, 32'h1F);
    apb(0, 12'h020, 0);
    chk({rd[30:0], err}, 32'h1);
    apb(1, 12'h018, 32'hA);
    apb(0, 12'h018, 0);
    chk(rd, 32'hA);
    chk(een, 4'hA);
    repeat (80) begin
      foreach (v[i]) v[i] = $urandom;
      foreach (v[i]) apb(1, 12'(4 * i), v[i]);
      dbg <= 1'($urandom);
      apb(0, 12'h008, 0);
      chk(rd, v[2] & 32'h1F);
      chk(err, 1'b0);
      @(negedge pclk);
      model();
      chk(pin_oe, ee);
      chk(pin_out & ee, eo & ee);
      chk({sdi, rx, sci, i13, i14}, ep);
      chk({dd, dc, dm}, dbg ? {pin_in[0], pin_in[2], pin_in[3]} : 3'b000);
      @(posedge pclk);
    end
    give_verdict();
  end
endmodule // port4_alternate_function_mux_tb
